// ==== tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // small divider keeps time-outs short
  localparam int LFD = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ws;
  logic wclr, slp, wake, ofail, incomp, wsr, halt, rlp, irq;
  logic [1:0] mode;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int fail_count, check_count, seed, i, k, n;
  int mreg [5];
  int cd [3] = '{0, 1, 'h13};
  wdtsr_top #(.LF_DIV(12'(LFD))) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wdt_mode_config(mode), .watchdog_clear_instr(wclr), .sleep_instr(slp),
    .wake_event(wake), .lf_osc_fail(ofail), .lp_incompat_periph_en(incomp),
    .wdt_sys_reset(wsr), .cpu_halt(halt), .regulator_low_power(rlp), .irq(irq));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until ready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 0;
    @(posedge pclk);
    penable <= 1;
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (pready !== 1'b1 && c < 50);
    // a ready that never came counts as a mismatch
    chk(pready, 1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    // idle edge, so the next call never reassigns psel in this step
    @(posedge pclk);
  endtask
  // model keeps field masks and one-to-clear status
  task automatic wr(input logic [7:0] a, input int d);
    apb(1, a, d);
    case (a)
      8'h00: mreg[0] = d & 'h3F;
      8'h04: mreg[1] = d & 'h3;
      8'h08: mreg[2] &= ~d;
      8'h0C: mreg[3] = d & 'h7;
    endcase
  endtask
  task automatic rdc(input logic [7:0] a);
    apb(0, a, 0);
    chk(rd, mreg[a >> 2]);
  endtask
  task automatic kick;
    wclr <= 1;
    @(posedge pclk);
    wclr <= 0;
  endtask
  task automatic run(input int lim, output int c);
    c = 0;
    while (wsr !== 1'b1 && c < lim) begin
      @(posedge pclk);
      c++;
    end
    if (wsr === 1'b1) mreg[2] |= 1;
  endtask
  task automatic nap;
    slp <= 1;
    @(posedge pclk);
    slp <= 0;
    repeat (2) @(posedge pclk);
  endtask
  // counts halted cycles; a reset while halted is noted
  task automatic up(output int c);
    c = 0;
    ws = 0;
    while (halt === 1'b1 && c < 2000) begin
      @(posedge pclk);
      c++;
      if (wsr === 1'b1) ws = 1;
    end
  endtask
  task automatic rise(output int c);
    wake <= 1;
    @(posedge pclk);
    wake <= 0;
    up(c);
  endtask
  task automatic give_verdict;
    $display("checks=%0d fails=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    fail_count++;
    give_verdict;
  end
  initial begin
    {presetn, psel, penable, pwrite, wclr, slp, wake, ofail, incomp} = 0;
    paddr = 0;
    pwdata = 0;
    mode = 0;
    seed = 63;
    mreg = '{'h16, 1, 0, 0, 0};
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    // every mapped word, the state word included, reads its reset value
    for (i = 0; i < 5; i++) rdc(i * 4);
    apb(0, 8'h14, 0);
    chk(err, 1);
    chk(rd, 0);
    // random period codes and enable read back
    for (i = 0; i < 4; i++) begin
      n = $random(seed);
      wr(0, n);
      rdc(0);
    end
    // time-out per code, reserved code acts as minimum
    foreach (cd[j]) begin
      wr(8, 7);
      wr('hC, j == 2 ? 0 : 7);
      wr(0, cd[j] << 1);
      rdc(0);
      mode <= 3;
      kick;
      n = (cd[j] <= 'h12 ? 32 << cd[j] : 32) * LFD;
      run(n + 20, k);
      mode <= 0;
      chk(k >= n - LFD && k <= n + 4, 1);
      repeat (2) @(posedge pclk);
      chk(irq, j != 2);
      rdc(8);
    end
    wr(8, 7);
    rdc(8);
    chk(irq, 0);
    wr('hC, 7);
    // every mode against the software enable bit
    for (i = 0; i < 8; i++) begin
      wr(0, i & 1);
      mode <= i[2:1];
      kick;
      run(200, k);
      mode <= 0;
      chk(k < 200, i >= 3);
      repeat (4) @(posedge pclk);
    end
    mode <= 3;
    repeat (6) begin
      kick;
      run(100, k);
      chk(k, 100);
    end
    ofail <= 1;
    // the failing edge raises its own sticky flag
    mreg[2] |= 4;
    run(300, k);
    chk(k, 300);
    ofail <= 0;
    kick;
    nap;
    chk(halt, 1);
    up(k);
    mode <= 0;
    chk({ws, 1'b0, k > 100 && k < 150}, 1);
    mreg[2] |= 2;
    rdc(8);
    mode <= 2;
    nap;
    repeat (300) @(posedge pclk);
    chk(halt, 1);
    rise(k);
    mode <= 0;
    chk(k < 3, 1);
    wr(4, 3);
    rdc(4);
    nap;
    chk(rlp, 1);
    rise(k);
    chk(k >= 1000 && k <= 1003, 1);
    incomp <= 1;
    nap;
    chk({halt, rlp}, 2);
    rise(k);
    chk(k < 3, 1);
    give_verdict;
  end
endmodule
`default_nettype wire

// ==== wdtsr_chk_sva.sv ====
`default_nettype none
module wdtsr_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] wdt_mode_config,
  input wire logic sleep_instr,
  input wire logic wake_event,
  input wire logic lf_osc_fail,
  input wire logic lp_incompat_periph_en,
  input wire logic wdt_sys_reset,
  input wire logic cpu_halt,
  input wire logic regulator_low_power
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus setup and sleep request as named steps
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence sleep_go;
    sleep_instr && !wake_event && !cpu_halt;
  endsequence
  ready_after_setup_a: assert property (apb_setup |=> pready)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  reset_pulse_a: assert property (wdt_sys_reset |=> !wdt_sys_reset)
    else $error("reset pulse too long");
  mode_off_a: assert property ((wdt_mode_config == 2'h0)[*3] |-> !wdt_sys_reset)
    else $error("reset while disabled");
  osc_fail_a: assert property (lf_osc_fail[*3] |-> !wdt_sys_reset)
    else $error("reset during osc fail");
  sleep_enter_a: assert property (sleep_go |=> cpu_halt)
    else $error("sleep not entered");
  lp_only_asleep_a: assert property (regulator_low_power |-> cpu_halt)
    else $error("low power while awake");
  lp_wake_delay_a: assert property
    ($fell(regulator_low_power) && !lp_incompat_periph_en |-> cpu_halt[*8])
    else $error("low power wake too fast");
  incompat_normal_a: assert property
    (lp_incompat_periph_en[*2] |-> !regulator_low_power)
    else $error("low power with incompat periph");
endmodule
bind wdtsr_top wdtsr_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .wdt_mode_config(wdt_mode_config), .sleep_instr(sleep_instr),
  .wake_event(wake_event), .lf_osc_fail(lf_osc_fail),
  .lp_incompat_periph_en(lp_incompat_periph_en), .wdt_sys_reset(wdt_sys_reset),
  .cpu_halt(cpu_halt), .regulator_low_power(regulator_low_power));
`default_nettype wire

// ==== wdtsr_consts.vh ====
`ifndef WDTSR_CONSTS_VH
`define WDTSR_CONSTS_VH

// clock rates and the low-frequency time base
`define WDTSR_PCLK_MHZ 100
`define WDTSR_PCLK_KHZ (`WDTSR_PCLK_MHZ * 1000)
`define WDTSR_LFOSC_KHZ 31
// pclk cycles per low-frequency tick, rounded to nearest
`define WDTSR_LF_DIV ((`WDTSR_PCLK_KHZ + (`WDTSR_LFOSC_KHZ / 2)) / `WDTSR_LFOSC_KHZ)
// nominal 1 ms base interval is 32 low-frequency ticks
`define WDTSR_BASE_MS 1
`define WDTSR_BASE_TICKS 32
// highest valid period select code, 2^23 prescale
`define WDTSR_PS_MAX 5'h12
`define WDTSR_PS_ALL_ONES 23'h7FFFFF

// extra stabilisation delay after low-power sleep
`define WDTSR_LP_WAKE_US 10
`define WDTSR_LP_WAKE_CYC (`WDTSR_LP_WAKE_US * `WDTSR_PCLK_MHZ)

// register offsets (byte addresses)
`define WDTSR_OFF_WDT_CTRL 8'h00
`define WDTSR_OFF_REG_CTRL 8'h04
`define WDTSR_OFF_IRQ_STAT 8'h08
`define WDTSR_OFF_IRQ_MASK 8'h0C
`define WDTSR_OFF_STATE 8'h10

// watchdog_control fields
`define WDTSR_WC_SWEN_BIT 0
`define WDTSR_WC_PS_LSB 1
`define WDTSR_WC_PS_MSB 5
`define WDTSR_WC_SWEN_RST 1'h0
`define WDTSR_WC_PS_RST 5'h0B

// regulator_sleep_control fields
`define WDTSR_RC_RSV_BIT 0
`define WDTSR_RC_PM_BIT 1
`define WDTSR_RC_RSV_RST 1'h1
`define WDTSR_RC_PM_RST 1'h0

// interrupt status and mask bits
`define WDTSR_IRQ_W 3
`define WDTSR_IRQ_RESET_BIT 0
`define WDTSR_IRQ_WAKE_BIT 1
`define WDTSR_IRQ_OSCF_BIT 2
`define WDTSR_IRQ_RST 3'h0

// watchdog mode configuration codes
`define WDTSR_MODE_OFF 2'h0
`define WDTSR_MODE_SW 2'h1
`define WDTSR_MODE_NOSLP 2'h2
`define WDTSR_MODE_ON 2'h3

`endif

// ==== wdtsr_lfosc.v ====
`include "wdtsr_consts.vh"
`default_nettype none

module wdtsr_lfosc #(
  parameter [11:0] LF_DIV = `WDTSR_LF_DIV
) (
  input wire pclk,
  input wire presetn,
  input wire osc_fail,
  output wire lf_tick
);

  localparam [11:0] LF_LAST = LF_DIV - 12'h001;

  reg [11:0] div_q;
  reg tick_q;

  ////////////////////////////////////////////////////////////////////////
  // free-running divider; a failed oscillator simply stops ticking
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 12'h000;
      tick_q <= 1'b0;
    end else if (osc_fail) begin
      div_q <= 12'h000;
      tick_q <= 1'b0;
    end else if (div_q == LF_LAST) begin
      div_q <= 12'h000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 12'h001;
      tick_q <= 1'b0;
    end
  end

  assign lf_tick = tick_q;

endmodule

`default_nettype wire

// ==== wdtsr_top.v ====
// Implementation choices: the APB slave port and the register addresses.
`include "wdtsr_consts.vh"
`default_nettype none

module wdtsr_top #(
  parameter [11:0] LF_DIV = `WDTSR_LF_DIV
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [1:0] wdt_mode_config,
  input wire watchdog_clear_instr,
  input wire sleep_instr,
  input wire wake_event,
  input wire lf_osc_fail,
  input wire lp_incompat_periph_en,
  output wire wdt_sys_reset,
  output wire cpu_halt,
  output wire regulator_low_power,
  output wire irq
);

  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_SLEEP = 2'h1;
  localparam [1:0] ST_WAKE = 2'h2;
  localparam integer LP_CYC = `WDTSR_LP_WAKE_CYC;
  localparam [10:0] LP_LAST = LP_CYC[10:0] - 11'h001;

  // register file
  reg [4:0] period_sel_q;
  reg sw_watchdog_enable_q;
  reg regulator_sleep_power_sel_q;
  reg reg_rsv_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  reg [2:0] irq_stat_d;
  reg [2:0] irq_mask_d;

  // sleep sequencing
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [10:0] dly_q;
  reg osc_fail_q;

  // outputs
  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;
  reg sys_reset_q;
  reg cpu_halt_q;
  reg reg_lp_q;
  reg irq_q;

  reg wdt_active;
  reg [31:0] rd_mux;
  wire asleep;
  wire sleep_go;
  wire wake_go;
  wire wdt_clear;
  wire wdt_to;
  wire lf_tick;
  wire fail_rise;
  wire [4:0] period_eff;
  wire apb_setup;
  wire apb_acc;
  wire apb_wr;
  wire [2:0] irq_set;
  wire [2:0] irq_clr;

  // exact-word decode of the mapped offsets
  function wdtsr_mapped;
    input [7:0] a;
    begin
      wdtsr_mapped = (a == `WDTSR_OFF_WDT_CTRL) || (a == `WDTSR_OFF_REG_CTRL) ||
                     (a == `WDTSR_OFF_IRQ_STAT) || (a == `WDTSR_OFF_IRQ_MASK) ||
                     (a == `WDTSR_OFF_STATE);
    end
  endfunction

  // reserved codes above the last valid one fall back to 1:32
  function [4:0] wdtsr_ps_eff;
    input [4:0] ps;
    begin
      if (ps > `WDTSR_PS_MAX) begin
        wdtsr_ps_eff = 5'h00;
      end else begin
        wdtsr_ps_eff = ps;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // mode decode; wake delay counts as awake since the counter restarts
  assign asleep = (state_q == ST_SLEEP);

  always @* begin
    case (wdt_mode_config)
      `WDTSR_MODE_ON: wdt_active = 1'b1;
      `WDTSR_MODE_NOSLP: wdt_active = !asleep;
      `WDTSR_MODE_SW: wdt_active = sw_watchdog_enable_q;
      default: wdt_active = 1'b0;
    endcase
  end

  // a pending wake event turns the sleep instruction into a no-op
  assign sleep_go = (state_q == ST_RUN) && sleep_instr && !wake_event;
  assign wake_go = asleep && (wake_event || wdt_to);
  assign fail_rise = lf_osc_fail && !osc_fail_q;

  // every clearing source; reset clears through presetn
  assign wdt_clear = watchdog_clear_instr || sleep_go || wake_go ||
                     lf_osc_fail || !wdt_active;

  assign period_eff = wdtsr_ps_eff(period_sel_q);

  ////////////////////////////////////////////////////////////////////////
  // independent time base and the watchdog counter
  wdtsr_lfosc #(
    .LF_DIV(LF_DIV)
  ) u_lfosc (
    .pclk(pclk),
    .presetn(presetn),
    .osc_fail(lf_osc_fail),
    .lf_tick(lf_tick)
  );

  wdtsr_wdt_cnt u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .lf_tick(lf_tick),
    .clear(wdt_clear),
    .period_sel(period_eff),
    .timeout(wdt_to)
  );

  ////////////////////////////////////////////////////////////////////////
  // sleep state machine
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (sleep_go) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_go) begin
          // only a low-power sleep pays the stabilisation delay
          state_d = reg_lp_q ? ST_WAKE : ST_RUN;
        end
      end
      ST_WAKE: begin
        if (dly_q == LP_LAST) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // state, wake delay and regulator mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RUN;
      dly_q <= 11'h000;
      osc_fail_q <= 1'b0;
      reg_lp_q <= 1'b0;
      cpu_halt_q <= 1'b0;
      sys_reset_q <= 1'b0;
    end else begin
      state_q <= state_d;
      osc_fail_q <= lf_osc_fail;
      if (state_q == ST_WAKE) begin
        dly_q <= dly_q + 11'h001;
      end else begin
        dly_q <= 11'h000;
      end
      // low power only while asleep and no peripheral objects
      reg_lp_q <= (state_d == ST_SLEEP) && regulator_sleep_power_sel_q &&
                  !lp_incompat_periph_en;
      cpu_halt_q <= (state_d != ST_RUN);
      // a time-out asleep wakes instead of resetting
      sys_reset_q <= wdt_to && !asleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait-free access phase, answer registered at setup
  assign apb_setup = psel && !penable;
  assign apb_acc = psel && penable && pready_q;
  assign apb_wr = apb_acc && pwrite;

  always @* begin
    rd_mux = 32'h00000000;
    case (paddr)
      `WDTSR_OFF_WDT_CTRL: begin
        rd_mux[`WDTSR_WC_PS_MSB:`WDTSR_WC_PS_LSB] = period_sel_q;
        rd_mux[`WDTSR_WC_SWEN_BIT] = sw_watchdog_enable_q;
      end
      `WDTSR_OFF_REG_CTRL: begin
        rd_mux[`WDTSR_RC_PM_BIT] = regulator_sleep_power_sel_q;
        rd_mux[`WDTSR_RC_RSV_BIT] = reg_rsv_q;
      end
      `WDTSR_OFF_IRQ_STAT: rd_mux[2:0] = irq_stat_q;
      `WDTSR_OFF_IRQ_MASK: rd_mux[2:0] = irq_mask_q;
      `WDTSR_OFF_STATE: rd_mux[4:0] = {lf_osc_fail, wdt_active, reg_lp_q, state_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= apb_setup;
      if (apb_setup) begin
        prdata_q <= pwrite ? 32'h00000000 : rd_mux;
        pslverr_q <= !wdtsr_mapped(paddr);
      end else if (apb_acc) begin
        pslverr_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers; reserved period codes are stored as written
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_sel_q <= `WDTSR_WC_PS_RST;
      sw_watchdog_enable_q <= `WDTSR_WC_SWEN_RST;
      regulator_sleep_power_sel_q <= `WDTSR_RC_PM_RST;
      reg_rsv_q <= `WDTSR_RC_RSV_RST;
    end else if (apb_wr) begin
      if (paddr == `WDTSR_OFF_WDT_CTRL) begin
        period_sel_q <= pwdata[`WDTSR_WC_PS_MSB:`WDTSR_WC_PS_LSB];
        sw_watchdog_enable_q <= pwdata[`WDTSR_WC_SWEN_BIT];
      end
      if (paddr == `WDTSR_OFF_REG_CTRL) begin
        regulator_sleep_power_sel_q <= pwdata[`WDTSR_RC_PM_BIT];
        // software is expected to write this back as one
        reg_rsv_q <= pwdata[`WDTSR_RC_RSV_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky event flags, write one to clear; a new event beats the clear
  assign irq_set[`WDTSR_IRQ_RESET_BIT] = wdt_to && !asleep;
  assign irq_set[`WDTSR_IRQ_WAKE_BIT] = wdt_to && asleep;
  assign irq_set[`WDTSR_IRQ_OSCF_BIT] = fail_rise;
  assign irq_clr = (apb_wr && (paddr == `WDTSR_OFF_IRQ_STAT)) ? pwdata[2:0] : 3'h0;

  always @* begin
    irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
    irq_mask_d = irq_mask_q;
    if (apb_wr && (paddr == `WDTSR_OFF_IRQ_MASK)) begin
      irq_mask_d = pwdata[2:0];
    end
  end

  // the flags sit apart from presetn consumers only by software choice
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= `WDTSR_IRQ_RST;
      irq_mask_q <= `WDTSR_IRQ_RST;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= |(irq_stat_d & irq_mask_d);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a flip-flop
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign wdt_sys_reset = sys_reset_q;
  assign cpu_halt = cpu_halt_q;
  assign regulator_low_power = reg_lp_q;
  assign irq = irq_q;

endmodule

`default_nettype wire

// ==== wdtsr_wdt_cnt.v ====
`include "wdtsr_consts.vh"
`default_nettype none

module wdtsr_wdt_cnt (
  input wire pclk,
  input wire presetn,
  input wire lf_tick,
  input wire clear,
  input wire [4:0] period_sel,
  output wire timeout
);

  reg [22:0] cnt_q;
  reg to_q;
  wire [22:0] term;

  // last tick count of a period: 2^(5+sel) ticks in all
  function [22:0] wdtsr_term;
    input [4:0] sel;
    begin
      wdtsr_term = `WDTSR_PS_ALL_ONES >> (`WDTSR_PS_MAX - sel);
    end
  endfunction

  assign term = wdtsr_term(period_sel);

  ////////////////////////////////////////////////////////////////////////
  // clear beats a coinciding time-out, so a last-moment clear still saves us
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 23'h000000;
      to_q <= 1'b0;
    end else if (clear) begin
      cnt_q <= 23'h000000;
      to_q <= 1'b0;
    end else if (lf_tick && (cnt_q >= term)) begin
      cnt_q <= 23'h000000;
      to_q <= 1'b1;
    end else begin
      if (lf_tick) begin
        cnt_q <= cnt_q + 23'h000001;
      end
      to_q <= 1'b0;
    end
  end

  assign timeout = to_q;

endmodule

`default_nettype wire
